// [core/table_if.sv]
// Access and lookup signals between the register logic and the table store.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface table_if;
	import vlan_table_pkg::*;
	logic                 req;
	logic                 sel;
	logic                 dir;
	logic [CMD_IDX_W-1:0] idx;
	logic [ENTRY_W-1:0]   wdata;
	logic                 done;
	logic [ENTRY_W-1:0]   rdata;
	logic [1:0]           lk_port;
	logic [VID_W-1:0]     lk_vid;
	logic                 lk_hit;
	logic [NUM_PORTS-1:0] lk_member;
	logic                 lk_untag;
	logic [VID_W-1:0]     pvid;
	logic [PRI_W-1:0]     ppri;
	modport ctrl (output req, sel, dir, idx, wdata, lk_port, lk_vid,
		input done, rdata, lk_hit, lk_member, lk_untag, pvid, ppri);
	modport store (input req, sel, dir, idx, wdata, lk_port, lk_vid,
		output done, rdata, lk_hit, lk_member, lk_untag, pvid, ppri);
endinterface : table_if

// [core/vlan_table_access_and_aging_cfg.sv]
// Register front end for the VLAN tables, packet classification and aging timer.
// Assumes a single register master that never issues both strobes at once.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module vlan_table_access_and_aging_cfg #(
	parameter logic [35:0] AGE_NORMAL_CYC = 36'(vlan_table_pkg::AGE_NORMAL_CYC),
	parameter logic [35:0] AGE_TEST_CYC   = 36'(vlan_table_pkg::AGE_TEST_CYC)
) (
	input  wire logic                                 clk_sys_i,
	input  wire logic                                 nrst_i,
	input  wire logic [vlan_table_pkg::ADDR_W-1:0]    reg_addr_i,
	input  wire logic [vlan_table_pkg::DATA_W-1:0]    reg_wdata_i,
	input  wire logic                                 reg_wr_i,
	input  wire logic                                 reg_rd_i,
	output logic      [vlan_table_pkg::DATA_W-1:0]    reg_rdata_o,
	input  wire logic                                 pkt_valid_i,
	input  wire logic [1:0]                           pkt_port_i,
	input  wire logic                                 pkt_tagged_i,
	input  wire logic [vlan_table_pkg::VID_W-1:0]     pkt_vid_i,
	input  wire logic [vlan_table_pkg::PRI_W-1:0]     pkt_pri_i,
	output logic                                      cls_valid_o,
	output logic      [vlan_table_pkg::VID_W-1:0]     cls_vid_o,
	output logic      [vlan_table_pkg::PRI_W-1:0]     cls_pri_o,
	output logic                                      cls_admit_o,
	output logic      [vlan_table_pkg::NUM_PORTS-1:0] cls_egress_o,
	output logic      [vlan_table_pkg::NUM_PORTS-1:0] cls_untag_o,
	output logic                                      age_test_o,
	output logic                                      age_tick_o
);
	import vlan_table_pkg::*;

	table_if tif ();

	vlan_table_store #(
		.NV (NUM_VLANS),
		.NP (NUM_PORTS)
	) u_store (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.tif       (tif)
	);

	logic                 age_test_r;
	logic                 age_test_d_r;
	logic [CMD_W-1:0]     cmd_r;
	logic [ENTRY_W-1:0]   wdata_r;
	logic [ENTRY_W-1:0]   rd_data_r;
	logic [PCTRL_W-1:0]   pctrl_r;
	logic                 launch_r;
	logic                 pending_r;
	logic [DATA_W-1:0]    rdata_r;
	logic [DATA_W-1:0]    rd_mux;
	logic [AGE_CNT_W-1:0] age_cnt_r;
	logic [AGE_CNT_W-1:0] age_limit;
	logic                 age_tick_r;
	logic                 wr_age;
	logic                 wr_cmd;
	logic                 wr_wdata;
	logic                 wr_pctrl;
	logic                 use_default;
	logic                 own_member;
	logic                 admit_nxt;
	logic [NUM_PORTS-1:0] admit_ctl;
	logic [NUM_PORTS-1:0] hybrid_ctl;
	logic [NUM_PORTS-1:0] egress_nxt;
	logic                 cls_valid_r;
	logic [VID_W-1:0]     cls_vid_r;
	logic [PRI_W-1:0]     cls_pri_r;
	logic                 cls_admit_r;
	logic [NUM_PORTS-1:0] cls_egress_r;
	logic [NUM_PORTS-1:0] cls_untag_r;

	// Write decode
	always_comb begin
		wr_age   = 1'b0;
		wr_cmd   = 1'b0;
		wr_wdata = 1'b0;
		wr_pctrl = 1'b0;
		if (reg_wr_i) begin
			if (reg_addr_i == ADDR_AGE_CFG) wr_age = 1'b1;
			else if (reg_addr_i == ADDR_CMD) wr_cmd = 1'b1;
			else if (reg_addr_i == ADDR_WDATA) wr_wdata = 1'b1;
			else if (reg_addr_i == ADDR_PORT_CTRL) wr_pctrl = 1'b1;
		end
	end

	// Configuration registers keep only their defined bits, except that pctrl_r also keeps unused bit 3
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			age_test_r <= 1'b0;
			cmd_r      <= CMD_RST;
			wdata_r    <= ENTRY_RST;
			pctrl_r    <= PCTRL_RST;
		end else begin
			if (wr_age) age_test_r <= reg_wdata_i[0]; // [RL17]
			if (wr_cmd) cmd_r <= reg_wdata_i[CMD_W-1:0]; // [RL17]
			if (wr_wdata) wdata_r <= reg_wdata_i[ENTRY_W-1:0]; // [RL17]
			if (wr_pctrl) pctrl_r <= reg_wdata_i[PCTRL_W-1:0];
		end
	end

	// Table access launch and completion tracking
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			launch_r <= 1'b0;
		end else begin
			launch_r <= wr_cmd; // [RL2]
		end
	end

	// A new command wins over a completion in the same cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pending_r <= 1'b0;
		end else if (wr_cmd) begin
			pending_r <= 1'b1; // [RL16]
		end else if (tif.done && !launch_r) begin
			pending_r <= 1'b0; // [RL16]
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_r <= ENTRY_RST;
		end else if (tif.done && cmd_r[CMD_DIR_BIT]) begin
			rd_data_r <= tif.rdata; // [RL3]
		end
	end

	assign tif.req   = launch_r;
	assign tif.dir   = cmd_r[CMD_DIR_BIT]; // [RL5]
	assign tif.sel   = cmd_r[CMD_SEL_BIT]; // [RL6]
	assign tif.idx   = cmd_r[CMD_IDX_W-1:0];
	assign tif.wdata = wdata_r;

	// Read decode; unmapped addresses read zero
	always_comb begin
		rd_mux = '0;
		if (reg_addr_i == ADDR_AGE_CFG) rd_mux[0] = age_test_r;
		else if (reg_addr_i == ADDR_CMD) rd_mux[CMD_W-1:0] = cmd_r;
		else if (reg_addr_i == ADDR_WDATA) rd_mux[ENTRY_W-1:0] = wdata_r;
		else if (reg_addr_i == ADDR_RDATA) rd_mux[ENTRY_W-1:0] = rd_data_r;
		else if (reg_addr_i == ADDR_STATUS) rd_mux[STS_PENDING] = pending_r;
		else if (reg_addr_i == ADDR_PORT_CTRL) rd_mux[PCTRL_W-1:0] = pctrl_r;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= reg_rd_i ? rd_mux : '0;
		end
	end

	// Aging period generator, restarted on a mode change
	assign age_limit = age_test_r ? AGE_TEST_CYC : AGE_NORMAL_CYC; // [RL1]

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			age_test_d_r <= 1'b0;
			age_cnt_r    <= '0;
			age_tick_r   <= 1'b0;
		end else begin
			age_test_d_r <= age_test_r;
			age_tick_r   <= 1'b0;
			if (age_test_d_r != age_test_r) begin
				age_cnt_r <= '0; // [RL1]
			end else if (age_cnt_r >= age_limit - 36'h1) begin
				age_cnt_r  <= '0;
				age_tick_r <= 1'b1; // [RL1]
			end else begin
				age_cnt_r <= age_cnt_r + 36'h1;
			end
		end
	end

	// Packet classification against the tables
	assign admit_ctl   = pctrl_r[ADMIT_LSB +: NUM_PORTS];
	assign hybrid_ctl  = pctrl_r[HYBRID_LSB +: NUM_PORTS];
	assign use_default = !pkt_tagged_i || (pkt_vid_i == '0); // [RL9]
	assign tif.lk_port = pkt_port_i;
	assign tif.lk_vid  = use_default ? tif.pvid : pkt_vid_i; // [RL9]

	always_comb begin
		own_member = 1'b0;
		admit_nxt  = 1'b0;
		if (32'(pkt_port_i) < NUM_PORTS) begin
			own_member = tif.lk_hit && tif.lk_member[pkt_port_i]; // [RL10]
			admit_nxt  = own_member || admit_ctl[pkt_port_i]; // [RL11]
		end
		egress_nxt = (admit_nxt && tif.lk_hit) ? tif.lk_member : '0; // [RL11]
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cls_valid_r  <= 1'b0;
			cls_vid_r    <= '0;
			cls_pri_r    <= '0;
			cls_admit_r  <= 1'b0;
			cls_egress_r <= '0;
			cls_untag_r  <= '0;
		end else begin
			cls_valid_r <= pkt_valid_i;
			if (pkt_valid_i) begin
				cls_vid_r    <= tif.lk_vid;
				cls_pri_r    <= use_default ? tif.ppri : pkt_pri_i; // [RL9]
				cls_admit_r  <= admit_nxt;
				cls_egress_r <= egress_nxt;
				cls_untag_r  <= tif.lk_untag ? (egress_nxt & hybrid_ctl) : '0; // [RL12]
			end
		end
	end

	assign reg_rdata_o  = rdata_r;
	assign cls_valid_o  = cls_valid_r;
	assign cls_vid_o    = cls_vid_r;
	assign cls_pri_o    = cls_pri_r;
	assign cls_admit_o  = cls_admit_r;
	assign cls_egress_o = cls_egress_r;
	assign cls_untag_o  = cls_untag_r;
	assign age_test_o   = age_test_r;
	assign age_tick_o   = age_tick_r;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	chk_age_restart: assert property ( // [RL1]
		(age_test_d_r != age_test_r) |=> (age_cnt_r == '0) && !age_tick_o)
		else $error("aging counter did not restart on mode change");

	chk_age_limit: assert property ( // [RL1]
		age_tick_r |-> $past(age_cnt_r) >= $past(age_limit) - 36'h1)
		else $error("aging tick before period elapsed");

	chk_cmd_launch: assert property ( // [RL2]
		wr_cmd |=> tif.req && tif.idx == $past(reg_wdata_i[CMD_IDX_W-1:0])
			&& tif.dir == $past(reg_wdata_i[CMD_DIR_BIT])
			&& tif.sel == $past(reg_wdata_i[CMD_SEL_BIT]))
		else $error("command write did not launch its access");

	chk_pending_span: assert property ( // [RL16]
		(wr_cmd && !pending_r) ##1 !wr_cmd [*2] |-> pending_r ##1 !pending_r)
		else $error("pending status wrong around a lone command");

	chk_pending_hold: assert property ( // [RL16]
		(pending_r && !tif.done) |=> pending_r)
		else $error("pending cleared before completion");

	chk_read_ready: assert property ( // [RL3]
		(pending_r && cmd_r[CMD_DIR_BIT]) ##1 !pending_r |-> rd_data_r == $past(tif.rdata))
		else $error("read data not present when pending clears");

	chk_reserved_zero: assert property ( // [RL17]
		(reg_rd_i && reg_addr_i == ADDR_CMD) |=> reg_rdata_o[DATA_W-1:CMD_W] == '0)
		else $error("reserved command bits read nonzero");

	chk_rdata_once: assert property (
		!reg_rd_i |=> reg_rdata_o == '0)
		else $error("read data outside the answer cycle");

	chk_default_vid: assert property ( // [RL9]
		(pkt_valid_i && use_default) |=> cls_vid_o == $past(tif.pvid)
			&& cls_pri_o == $past(tif.ppri))
		else $error("port default not applied");

	chk_nonmember_drop: assert property ( // [RL11]
		(pkt_valid_i && !own_member && !admit_ctl[pkt_port_i]) |=> !cls_admit_o
			&& cls_egress_o == '0)
		else $error("non-member packet admitted");

	chk_untag_hybrid: assert property ( // [RL12]
		cls_valid_o |-> (cls_untag_o & ~(cls_egress_o & hybrid_ctl)) == '0)
		else $error("untag outside hybrid members");

	chk_age_test_copy: assert property ( // [RL1]
		wr_age |=> age_test_o == $past(reg_wdata_i[0]))
		else $error("aging test output does not follow its register");

	chk_tick_single: assert property ( // [RL1]
		age_tick_r |=> !age_tick_r)
		else $error("aging tick longer than one cycle");

	chk_pending_set: assert property ( // [RL16]
		wr_cmd |=> pending_r)
		else $error("pending not set after command write");

	chk_store_answer: assert property ( // [RL16]
		tif.req |=> tif.done)
		else $error("table store did not answer its request");

	chk_rd_data_hold: assert property ( // [RL3]
		!(tif.done && cmd_r[CMD_DIR_BIT]) |=> $stable(rd_data_r))
		else $error("read data changed without a read completion");

	chk_cls_valid_follow: assert property (
		1'b1 |=> cls_valid_o == $past(pkt_valid_i))
		else $error("classification valid not one cycle behind input");

	chk_cls_hold: assert property (
		!pkt_valid_i |=> $stable(cls_vid_o) && $stable(cls_pri_o) && $stable(cls_admit_o))
		else $error("classification result changed without a packet");

	cov_table_read: cover property (wr_cmd && reg_wdata_i[CMD_DIR_BIT] ##[1:4] !pending_r);
	cov_table_write: cover property (wr_cmd && !reg_wdata_i[CMD_DIR_BIT] ##[1:4] !pending_r);
	cov_back_to_back: cover property (wr_cmd ##1 wr_cmd);
	cov_admit_override: cover property (pkt_valid_i && !own_member && admit_nxt);
	cov_age_tick: cover property (age_test_r && age_tick_r);
endmodule : vlan_table_access_and_aging_cfg

// [core/vlan_table_pkg.sv]
// Register map, field layout and timing constants for the VLAN table access block.
// Assumes a 200 MHz core clock and registers at word index times four.
// Notes on behaviour
// (RL1) Age test bit shortens aging to 50 ms
// (RL2) Each command write launches one table access
// (RL3) Read data valid once pending status clears
// (RL4) Software loads write data before write command
// (RL5) Bit 5 selects read (1) or write (0)
// (RL6) Bit 4 selects port VID or VLAN table
// (RL7) Index 0-15 for VLANs, 0-2 for ports
// (RL8) Port entry: VID bits 11:0, priority 14:12
// (RL9) Untagged or null VID gets port defaults
// (RL10) Member bit 17 admits and broadcasts port 2
// (RL11) Non-members dropped unless admit control set
// (RL12) Untag bit 16 strips tag on hybrid egress
// (RL13) Ports 1 and 0 use bits 15..12
// (RL14) VID zero marks an entry disabled
// (RL15) Software never programs VID 3FFh
// (RL16) Pending set on command, cleared when done
// (RL17) Reserved bits read zero, ignore writes; the unused pctrl_r bit 3 is stored and reads back
package vlan_table_pkg;
	localparam int          ADDR_W         = 16;
	localparam int          DATA_W         = 32;
	localparam int          NUM_VLANS      = 16;
	localparam int          NUM_PORTS      = 3;
	localparam logic [13:0] IDX_AGE_CFG    = 14'h1809;
	localparam logic [13:0] IDX_CMD        = 14'h180B;
	localparam logic [13:0] IDX_WDATA      = 14'h180C;
	localparam logic [13:0] IDX_RDATA      = 14'h180E;
	localparam logic [13:0] IDX_STATUS     = 14'h1810;
	localparam logic [13:0] IDX_PORT_CTRL  = 14'h1811;
	localparam logic [ADDR_W-1:0] ADDR_AGE_CFG   = {IDX_AGE_CFG, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CMD       = {IDX_CMD, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_WDATA     = {IDX_WDATA, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_RDATA     = {IDX_RDATA, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PORT_CTRL = {IDX_PORT_CTRL, 2'b00};
	localparam int          CMD_W          = 6;
	localparam int          CMD_DIR_BIT    = 5;
	localparam int          CMD_SEL_BIT    = 4;
	localparam int          CMD_IDX_W      = 4;
	localparam logic [CMD_W-1:0] CMD_RST   = 6'h00;
	localparam int          ENTRY_W        = 18;
	localparam int          VID_W          = 12;
	localparam int          PRI_LSB        = 12;
	localparam int          PRI_W          = 3;
	localparam int          PVID_W         = 15;
	localparam int          UNTAG_LSB      = 12;
	localparam int          MEMBER_LSB     = 13;
	localparam logic [ENTRY_W-1:0] ENTRY_RST = 18'h00000;
	localparam int          PCTRL_W        = 7;
	localparam int          ADMIT_LSB      = 0;
	localparam int          HYBRID_LSB     = 4;
	localparam logic [PCTRL_W-1:0] PCTRL_RST = 7'h00;
	localparam int          STS_PENDING    = 0;
	localparam int          AGE_CNT_W      = 36;
	localparam longint unsigned CLK_HZ         = 64'd200_000_000;
	localparam longint unsigned AGE_NORMAL_MIN = 64'd5;
	localparam longint unsigned AGE_TEST_MS    = 64'd50;
	localparam longint unsigned AGE_NORMAL_CYC = AGE_NORMAL_MIN * 64'd60 * CLK_HZ;
	localparam longint unsigned AGE_TEST_CYC   = AGE_TEST_MS * CLK_HZ / 64'd1000;
endpackage : vlan_table_pkg

// [core/vlan_table_store.sv]
// VLAN membership table and per-port default VID table with lookup.
// Assumes one access request at a time, answered one cycle later.
`timescale 1ns/100ps
module vlan_table_store #(
	parameter int NV = vlan_table_pkg::NUM_VLANS,
	parameter int NP = vlan_table_pkg::NUM_PORTS
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	table_if.store   tif
);
	import vlan_table_pkg::*;

	logic [ENTRY_W-1:0] vlan_mem_r [NV];
	logic [PVID_W-1:0]  pvid_mem_r [NP];
	logic               done_r;
	logic [ENTRY_W-1:0] rdata_r;
	logic [NV-1:0]      hit;
	logic [ENTRY_W-1:0] match_entry;
	logic [NP-1:0]      untag_vec;
	logic               port_ok;
	logic               idx_port_ok;

	assign port_ok     = 32'(tif.lk_port) < NP;
	assign idx_port_ok = 32'(tif.idx) < NP;

	// Table writes; out-of-range port indices are dropped
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int v = 0; v < NV; v++) vlan_mem_r[v] <= ENTRY_RST;
			for (int p = 0; p < NP; p++) pvid_mem_r[p] <= '0;
		end else if (tif.req && !tif.dir) begin // [RL5]
			if (tif.sel) begin // [RL6]
				if (idx_port_ok) pvid_mem_r[tif.idx[1:0]] <= tif.wdata[PVID_W-1:0]; // [RL8]
			end else begin
				vlan_mem_r[tif.idx] <= tif.wdata; // [RL13]
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_r  <= 1'b0;
			rdata_r <= ENTRY_RST;
		end else begin
			done_r <= tif.req;
			if (tif.req && tif.dir) begin
				if (!tif.sel) rdata_r <= vlan_mem_r[tif.idx];
				else if (idx_port_ok)
					rdata_r <= {{(ENTRY_W-PVID_W){1'b0}}, pvid_mem_r[tif.idx[1:0]]};
				else rdata_r <= ENTRY_RST;
			end
		end
	end

	// Disabled entries carry VID zero and never match
	for (genvar v = 0; v < NV; v++) begin : g_match
		assign hit[v] = (vlan_mem_r[v][VID_W-1:0] == tif.lk_vid) &&
			(vlan_mem_r[v][VID_W-1:0] != '0); // [RL14]
	end

	always_comb begin
		match_entry = ENTRY_RST;
		for (int v = NV - 1; v >= 0; v--) begin
			if (hit[v]) match_entry = vlan_mem_r[v];
		end
	end

	for (genvar p = 0; p < NP; p++) begin : g_port
		assign tif.lk_member[p] = match_entry[MEMBER_LSB + 2 * p]; // [RL10] [RL13]
		assign untag_vec[p]     = match_entry[UNTAG_LSB + 2 * p]; // [RL12]
	end

	assign tif.lk_hit   = |hit;
	assign tif.lk_untag = port_ok ? untag_vec[tif.lk_port] : 1'b0;
	assign tif.pvid     = port_ok ? pvid_mem_r[tif.lk_port][VID_W-1:0] : '0; // [RL8]
	assign tif.ppri     = port_ok ? pvid_mem_r[tif.lk_port][PRI_LSB +: PRI_W] : '0;
	assign tif.done     = done_r;
	assign tif.rdata    = rdata_r;
endmodule : vlan_table_store

// [dv/vlan_table_access_and_aging_cfg_tb.sv]
// Self-checking bench for the VLAN table access, classification and aging block.
// Assumes the register map and entry layout of vlan_table_pkg and a 200 MHz clock.
`timescale 1ns/100ps
module vlan_table_access_and_aging_cfg_tb;
	import vlan_table_pkg::*;
	localparam int AGE_N = 40;
	localparam int AGE_T = 8;
	logic              clk_sys_i    = 1'b0;
	logic              nrst_i       = 1'b0;
	logic [15:0]       reg_addr_i   = 16'h0000;
	logic [31:0]       reg_wdata_i  = 32'h0000_0000;
	logic              reg_wr_i     = 1'b0;
	logic              reg_rd_i     = 1'b0;
	logic [31:0]       reg_rdata_o;
	logic              pkt_valid_i  = 1'b0;
	logic [1:0]        pkt_port_i   = 2'h0;
	logic              pkt_tagged_i = 1'b0;
	logic [11:0]       pkt_vid_i    = 12'h000;
	logic [2:0]        pkt_pri_i    = 3'h0;
	logic              cls_valid_o;
	logic [11:0]       cls_vid_o;
	logic [2:0]        cls_pri_o;
	logic              cls_admit_o;
	logic [2:0]        cls_egress_o;
	logic [2:0]        cls_untag_o;
	logic              age_test_o;
	logic              age_tick_o;
	int                fails        = 0;
	int                cmp_count    = 0;
	int                cycles       = 0;

	vlan_table_access_and_aging_cfg #(
		.AGE_NORMAL_CYC(36'(AGE_N)),
		.AGE_TEST_CYC  (36'(AGE_T))
	) i_vlan_table_access_and_aging_cfg (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .pkt_valid_i(pkt_valid_i), .pkt_port_i(pkt_port_i),
		.pkt_tagged_i(pkt_tagged_i), .pkt_vid_i(pkt_vid_i), .pkt_pri_i(pkt_pri_i),
		.cls_valid_o(cls_valid_o), .cls_vid_o(cls_vid_o), .cls_pri_o(cls_pri_o),
		.cls_admit_o(cls_admit_o), .cls_egress_o(cls_egress_o), .cls_untag_o(cls_untag_o),
		.age_test_o(age_test_o), .age_tick_o(age_tick_o)
	);

	always #2.5 clk_sys_i = ~clk_sys_i;

	task automatic end_sim;
		if (fails == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	// Hang guard well beyond the expected run length
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_sim();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i   <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		check(d, exp);
	endtask : rd_chk

	// Poll pending until clear, bounded
	task automatic poll;
		logic [31:0] d;
		int          n;
		n = 0;
		do begin
			rd(ADDR_STATUS, d);
			n++;
		end while (d[STS_PENDING] !== 1'b0 && n < 10);
		check({31'h0, d[STS_PENDING]}, 32'h0);
	endtask : poll

	task automatic pkt(input logic [1:0] p, input logic t, input logic [11:0] v,
			input logic [2:0] pr, input logic [31:0] exp);
		@(posedge clk_sys_i);
		pkt_valid_i  <= 1'b1;
		pkt_port_i   <= p;
		pkt_tagged_i <= t;
		pkt_vid_i    <= v;
		pkt_pri_i    <= pr;
		@(posedge clk_sys_i);
		pkt_valid_i  <= 1'b0;
		#1 check({9'h0, cls_valid_o, cls_admit_o, cls_egress_o, cls_untag_o,
			cls_pri_o, cls_vid_o}, exp);
	endtask : pkt

	// Cycles between two consecutive aging ticks
	task automatic tick_gap(output int n);
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (age_tick_o !== 1'b1 && n < 200);
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (age_tick_o !== 1'b1 && n < 200);
	endtask : tick_gap

	task automatic t_reset;
		rd_chk(ADDR_AGE_CFG, 32'h0);
		rd_chk(ADDR_CMD, 32'h0);
		rd_chk(ADDR_STATUS, 32'h0);
		rd_chk(16'h0100, 32'h0);
		check({31'h0, age_test_o}, 32'h0);
	endtask : t_reset

	task automatic t_aging;
		int n;
		wr(ADDR_AGE_CFG, 32'hFFFF_FFFF);
		rd_chk(ADDR_AGE_CFG, 32'h1);
		check({31'h0, age_test_o}, 32'h1);
		tick_gap(n);
		check(32'(n), 32'(AGE_T));
		wr(ADDR_AGE_CFG, 32'h0);
		tick_gap(n);
		check(32'(n), 32'(AGE_N));
	endtask : t_aging

	task automatic t_vlan_rw;
		wr(ADDR_WDATA, 32'hFFFF_FFFF);
		rd_chk(ADDR_WDATA, 32'h0003_FFFF);
		wr(ADDR_CMD, 32'hFFFF_FFC3);
		rd_chk(ADDR_STATUS, 32'h1);
		rd_chk(ADDR_CMD, 32'h0000_0003);
		poll();
		wr(ADDR_WDATA, 32'h0);
		wr(ADDR_CMD, 32'h23);
		poll();
		rd_chk(ADDR_RDATA, 32'h0003_FFFF);
	endtask : t_vlan_rw

	task automatic t_port;
		wr(ADDR_WDATA, 32'h5123);
		wr(ADDR_CMD, 32'h11);
		poll();
		wr(ADDR_CMD, 32'h31);
		poll();
		rd_chk(ADDR_RDATA, 32'h5123);
		pkt(2'd1, 1'b0, 12'h777, 3'h2, 32'h0040_5123);
		pkt(2'd1, 1'b1, 12'h000, 3'h2, 32'h0040_5123);
		pkt(2'd0, 1'b0, 12'h777, 3'h2, 32'h0040_0000);
		pkt(2'd1, 1'b1, 12'h777, 3'h2, 32'h0040_2777);
	endtask : t_port

	task automatic t_member;
		wr(ADDR_WDATA, 32'h0003_2055);
		wr(ADDR_CMD, 32'h02);
		poll();
		wr(ADDR_PORT_CTRL, 32'h10);
		pkt(2'd2, 1'b1, 12'h055, 3'h1, 32'h0074_9055);
		pkt(2'd1, 1'b1, 12'h055, 3'h1, 32'h0040_1055);
		wr(ADDR_PORT_CTRL, 32'h12);
		pkt(2'd1, 1'b1, 12'h055, 3'h1, 32'h0074_1055);
		wr(ADDR_WDATA, 32'h0003_2000);
		wr(ADDR_CMD, 32'h02);
		poll();
		pkt(2'd2, 1'b1, 12'h055, 3'h1, 32'h0040_1055);
	endtask : t_member

	initial begin
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		t_reset();
		t_aging();
		t_vlan_rw();
		t_port();
		t_member();
		end_sim();
	end
endmodule : vlan_table_access_and_aging_cfg_tb
